// *** sap_pkg.sv ***
package sap_pkg;

  // Register map and layout of the routing mask
  localparam int          REG_W          = 24;
  localparam logic [7:0]  ROUTE_MASK_OFS = 8'h28;
  localparam logic [23:0] ROUTE_MASK_RST = 24'h000000;
  localparam logic [23:0] ROUTE_IMPL     = 24'hFFFFFE;

  // Field positions, channel one at the high end of each group
  localparam int OVERCURRENT_HI  = 23;
  localparam int UNDERCURRENT_HI = 19;
  localparam int OVERVOLTAGE_HI  = 15;
  localparam int UNDERVOLTAGE_HI = 11;
  localparam int OVERPOWER_HI    = 7;
  localparam int ACCUM_FULL_BIT  = 3;
  localparam int COUNT_FULL_BIT  = 2;
  localparam int CONV_PULSE_BIT  = 1;
  localparam int UNIMPL_BIT      = 0;

  // Conversion-done pulse timing
  localparam int CLK_PERIOD_NS   = 40;
  localparam int CONV_PULSE_NS   = 5000;
  localparam int CONV_PULSE_CYC  = CONV_PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W     = 7;
  localparam logic [6:0] PULSE_CNT_RST = 7'h00;

  // Pulse generator states
  typedef enum logic [1:0] {
    SAP_IDLE  = 2'b01,
    SAP_PULSE = 2'b10
  } sap_pulse_state_e;

endpackage

// *** sap_pulse_if.sv ***
`timescale 1ns/1ps
// Conversion-done start strobe and stretched pulse between the two modules
interface sap_pulse_if;
  logic start;
  logic active;

  modport src (output start, input active);
  modport gen (input start, output active);
endinterface

// *** sap_pulse_gen.sv ***
`timescale 1ns/1ps
module sap_pulse_gen (
  input  wire logic clk,
  input  wire logic sys_rst,
  sap_pulse_if.gen  pulse
);

  localparam logic [6:0] LAST_CNT =
    7'(sap_pkg::CONV_PULSE_CYC - 1);

  sap_pkg::sap_pulse_state_e state;
  sap_pkg::sap_pulse_state_e next_state;
  logic [sap_pkg::PULSE_CNT_W-1:0] cnt;
  logic [sap_pkg::PULSE_CNT_W-1:0] next_cnt;

  // A new completion restarts the count, so back-to-back ends merge into one longer pulse
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      sap_pkg::SAP_IDLE: begin
        if (pulse.start) begin
          next_state = sap_pkg::SAP_PULSE;
          next_cnt   = sap_pkg::PULSE_CNT_RST;
        end
      end
      sap_pkg::SAP_PULSE: begin
        if (pulse.start) begin
          next_cnt = sap_pkg::PULSE_CNT_RST;
        end else if (cnt == LAST_CNT) begin
          next_state = sap_pkg::SAP_IDLE;
          next_cnt   = sap_pkg::PULSE_CNT_RST;
        end else begin
          next_cnt = cnt + 7'h01;
        end
      end
      default: begin
        next_state = sap_pkg::SAP_IDLE;
        next_cnt   = sap_pkg::PULSE_CNT_RST;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= sap_pkg::SAP_IDLE;
      cnt   <= sap_pkg::PULSE_CNT_RST;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign pulse.active = (state == sap_pkg::SAP_PULSE);

  // Length of the pulse since its last start, for checking only
  logic [7:0] run_len;
  always_ff @(posedge clk) begin
    if (sys_rst || pulse.start) begin
      run_len <= 8'h00;
    end else if (pulse.active) begin
      run_len <= run_len + 8'h01;
    end
  end

  property p_pulse_len;
    @(posedge clk) disable iff (sys_rst)
      $fell(pulse.active) |-> (run_len == 8'(sap_pkg::CONV_PULSE_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("conversion pulse length wrong");

  property p_pulse_start;
    @(posedge clk) disable iff (sys_rst)
      pulse.start |=> pulse.active;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("conversion pulse did not start");

endmodule

// *** sap_route.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - A writable routing mask at 28h picks sources for the second pin.
// - Routing drives the pin only while the pin is in alert function.
// - A routed source reaches the pin only if its alert is also enabled.
// - Bits 23 to 20 route overcurrent alerts of channels one to four.
// - Bits 19 to 16 route undercurrent alerts of channels one to four.
// - Bits 15 to 12 route overvoltage alerts of channels one to four.
// - Bits 11 to 8 route undervoltage alerts of channels one to four.
// - Bit 0 is unimplemented, reads zero and ignores writes.
// - Bits 7 to 4 route overpower alerts of channels one to four.
// - Bit 3 routes the any-channel accumulator full alert.
// - Bit 2 routes the accumulation count full alert.
// - Bit 1 holds the pin high until 5 us after the last conversion end.
module sap_route (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic      [23:0] reg_rdata,
  output logic             reg_rd_valid,
  input  wire logic        pin_alert_func,
  input  wire logic [23:0] alert_enable,
  input  wire logic [23:0] alert_source,
  input  wire logic        conv_done,
  output logic             second_alert_pin
);

  localparam logic [23:0] ONE_HOT_PULSE =
    24'h000001 << sap_pkg::CONV_PULSE_BIT;

  // Address decode shared by reads and writes
  function automatic logic hits_mask(input logic [7:0] addr);
    return addr == sap_pkg::ROUTE_MASK_OFS;
  endfunction

  logic [23:0] second_alert_pin_route_mask;
  logic [23:0] next_route_mask;
  logic [23:0] next_rdata;
  logic        next_rd_valid;
  logic [23:0] qualified;
  logic        next_pin;

  sap_pulse_if pulse_bus ();

  assign pulse_bus.start = conv_done;

  sap_pulse_gen u_pulse (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pulse   (pulse_bus)
  );

  // Register port; unmapped reads return zero, unmapped writes are dropped
  always_comb begin
    next_route_mask = second_alert_pin_route_mask;
    next_rdata      = 24'h000000;
    next_rd_valid   = reg_rd_en;
    if (reg_wr_en && hits_mask(reg_addr)) begin
      next_route_mask = reg_wdata & sap_pkg::ROUTE_IMPL;
    end
    if (reg_rd_en && hits_mask(reg_addr)) begin
      next_rdata = second_alert_pin_route_mask & sap_pkg::ROUTE_IMPL;
    end
  end

  // Register state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_alert_pin_route_mask <= sap_pkg::ROUTE_MASK_RST;
      reg_rdata                   <= 24'h000000;
      reg_rd_valid                <= 1'b0;
    end else begin
      second_alert_pin_route_mask <= next_route_mask;
      reg_rdata                   <= next_rdata;
      reg_rd_valid                <= next_rd_valid;
    end
  end

  // Level sources: bits 23 down to 2 share one layout across both registers
  genvar g;
  generate
    for (g = sap_pkg::COUNT_FULL_BIT; g < sap_pkg::REG_W; g++) begin : g_lvl
      assign qualified[g] = second_alert_pin_route_mask[g] &
                            alert_enable[g] &
                            alert_source[g];
    end
  endgenerate

  // The stretched pulse stands in for the raw completion strobe
  assign qualified[sap_pkg::CONV_PULSE_BIT] =
    second_alert_pin_route_mask[sap_pkg::CONV_PULSE_BIT] &
    alert_enable[sap_pkg::CONV_PULSE_BIT] & pulse_bus.active;
  assign qualified[sap_pkg::UNIMPL_BIT] = 1'b0;

  // Outside alert function the pin belongs to other logic, so hold it low
  always_comb begin
    next_pin = pin_alert_func & (|qualified);
  end

  // Pin register; one cycle of latency from source to pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      second_alert_pin <= 1'b0;
    end else begin
      second_alert_pin <= next_pin;
    end
  end

  property p_write_store;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr_en && reg_addr == 8'h28) |=>
        (second_alert_pin_route_mask == ($past(reg_wdata) & 24'hFFFFFE));
  endproperty
  a_write_store: assert property (p_write_store)
    else $error("routing mask write not stored");

  property p_read_back;
    @(posedge clk) disable iff (sys_rst)
      (reg_rd_en && reg_addr == 8'h28 && !reg_wr_en) |=>
        reg_rd_valid && (reg_rdata == $past(second_alert_pin_route_mask));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("routing mask read wrong");

  property p_bit0_zero;
    @(posedge clk) disable iff (sys_rst)
      reg_rd_valid |-> (reg_rdata[0] == 1'b0);
  endproperty
  a_bit0_zero: assert property (p_bit0_zero)
    else $error("unimplemented bit read as one");

  property p_func_gate;
    @(posedge clk) disable iff (sys_rst)
      !pin_alert_func |=> !second_alert_pin;
  endproperty
  a_func_gate: assert property (p_func_gate)
    else $error("pin driven outside alert function");

  property p_enable_gate;
    @(posedge clk) disable iff (sys_rst)
      ((alert_enable & second_alert_pin_route_mask &
        ~ONE_HOT_PULSE) == 24'h000000 &&
       !alert_enable[1]) |=> !second_alert_pin;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("pin driven by a source not enabled");

  property p_or_only;
    @(posedge clk) disable iff (sys_rst)
      second_alert_pin |-> $past(pin_alert_func) &&
        ($past(qualified) != 24'h000000);
  endproperty
  a_or_only: assert property (p_or_only)
    else $error("pin high without a qualified source");

  property p_overcurrent;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[20] &&
       alert_enable[20] && alert_source[20]) |=> second_alert_pin;
  endproperty
  a_overcurrent: assert property (p_overcurrent)
    else $error("channel four overcurrent not routed");

  property p_undercurrent;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[19] &&
       alert_enable[19] && alert_source[19]) |=> second_alert_pin;
  endproperty
  a_undercurrent: assert property (p_undercurrent)
    else $error("channel one undercurrent not routed");

  property p_overvoltage;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[13] &&
       alert_enable[13] && alert_source[13]) |=> second_alert_pin;
  endproperty
  a_overvoltage: assert property (p_overvoltage)
    else $error("channel three overvoltage not routed");

  property p_undervoltage;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[8] &&
       alert_enable[8] && alert_source[8]) |=> second_alert_pin;
  endproperty
  a_undervoltage: assert property (p_undervoltage)
    else $error("channel four undervoltage not routed");

  property p_overpower;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[6] &&
       alert_enable[6] && alert_source[6]) |=> second_alert_pin;
  endproperty
  a_overpower: assert property (p_overpower)
    else $error("channel two overpower not routed");

  property p_accum;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[3] &&
       alert_enable[3] && alert_source[3]) |=> second_alert_pin;
  endproperty
  a_accum: assert property (p_accum)
    else $error("accumulator full not routed");

  property p_count;
    @(posedge clk) disable iff (sys_rst)
      (pin_alert_func && second_alert_pin_route_mask[2] &&
       alert_enable[2] && alert_source[2]) |=> second_alert_pin;
  endproperty
  a_count: assert property (p_count)
    else $error("count full not routed");

  property p_conv_pulse;
    @(posedge clk) disable iff (sys_rst)
      (conv_done && pin_alert_func && second_alert_pin_route_mask[1] &&
       alert_enable[1]) ##1
      (pin_alert_func && second_alert_pin_route_mask[1] &&
       alert_enable[1]) |=> second_alert_pin;
  endproperty
  a_conv_pulse: assert property (p_conv_pulse)
    else $error("conversion pulse missing on pin");

  property p_reset_clear;
    @(posedge clk) sys_rst |=> (second_alert_pin_route_mask == 24'h000000);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("routing mask not cleared by reset");

endmodule

// *** sap_host_model.sv ***
`timescale 1ns/1ps
// Host side watching the second alert pin: measures each high run
module sap_host_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        second_alert_pin,
  output logic      [15:0] high_width,
  output logic      [15:0] pulse_count
);
  logic [15:0] run;
  logic [15:0] next_run;
  logic [15:0] next_high_width;
  logic [15:0] next_pulse_count;

  // Width is latched on the falling edge so a held alert never counts
  always_comb begin
    next_run         = second_alert_pin ? run + 16'h0001 : 16'h0000;
    next_high_width  = high_width;
    next_pulse_count = pulse_count;
    if (!second_alert_pin && run != 16'h0000) begin
      next_high_width  = run;
      next_pulse_count = pulse_count + 16'h0001;
    end
  end

  // Counters cleared together with the device
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run         <= 16'h0000;
      high_width  <= 16'h0000;
      pulse_count <= 16'h0000;
    end else begin
      run         <= next_run;
      high_width  <= next_high_width;
      pulse_count <= next_pulse_count;
    end
  end
endmodule

// *** sap_route_tb_top.sv ***
`timescale 1ns/1ps
module sap_route_tb_top;
  logic        clk = 1'b0;
  logic        sys_rst, reg_wr_en, reg_rd_en, pin_alert_func, conv_done;
  logic [7:0]  reg_addr;
  logic [23:0] reg_wdata, reg_rdata, alert_enable, alert_source, d;
  logic        reg_rd_valid, second_alert_pin;
  logic [23:0] pin24;
  localparam logic [23:0] PULSE_EXP = 24'(sap_pkg::CONV_PULSE_CYC);
  logic [15:0] high_width, pulse_count, pc;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  sap_route dut_u (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .pin_alert_func(pin_alert_func), .alert_enable(alert_enable),
    .alert_source(alert_source), .conv_done(conv_done),
    .second_alert_pin(second_alert_pin));

  sap_host_model host_u (.clk(clk), .sys_rst(sys_rst),
    .second_alert_pin(second_alert_pin), .high_width(high_width),
    .pulse_count(pulse_count));

  // Pin widened for the common compare task
  assign pin24 = {23'h0, second_alert_pin};

  task automatic check(input logic [23:0] seen, input logic [23:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d, compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Single write strobe, mask updates at the edge that drops it
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] v);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  // Read answer stands one cycle only, so it is taken right after the edge
  task automatic rd_reg(input logic [7:0] a, output logic [23:0] v);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    check({23'h0, reg_rd_valid}, 24'h000001, "read valid missing");
    v = reg_rdata;
  endtask

  // Apply pin inputs, then look at the pin one edge later
  task automatic apply(input logic f, input logic [23:0] en,
                       input logic [23:0] src);
    @(posedge clk);
    pin_alert_func <= f;
    alert_enable   <= en;
    alert_source   <= src;
    @(posedge clk);
    #1;
  endtask

  task automatic conv_pulse();
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (140) @(posedge clk);
    #1;
  endtask

  task automatic t_reset_and_regs();
    rd_reg(sap_pkg::ROUTE_MASK_OFS, d);
    check(d, sap_pkg::ROUTE_MASK_RST, "mask not clear at reset");
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'hFFFFFF);
    wr_reg(8'h29, 24'h000000);
    rd_reg(sap_pkg::ROUTE_MASK_OFS, d);
    check(d, 24'hFFFFFE, "mask readback wrong");
    rd_reg(8'h29, d);
    check(d, 24'h000000, "unmapped read not zero");
  endtask

  // One routed bit at a time, all alerts enabled
  task automatic t_route_each_bit();
    for (int b = 2; b < 24; b++) begin
      apply(1'b1, 24'h000000, 24'h000000);
      wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'h000001 << b);
      apply(1'b1, 24'hFFFFFF, 24'h000001 << b);
      check(pin24, 24'h000001,
            "routed source lost");
      apply(1'b1, 24'hFFFFFF, ~(24'h000001 << b));
      check(pin24, 24'h000000, "unrouted source drove");
    end
  endtask

  task automatic t_gating();
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'hFFFFFC);
    apply(1'b1, 24'h000000, 24'hFFFFFF);
    check(pin24, 24'h000000, "disabled source drove");
    apply(1'b0, 24'hFFFFFF, 24'hFFFFFF);
    check(pin24, 24'h000000, "pin not in alert drove");
    apply(1'b1, 24'hFFFFFF, 24'hFFFFFF);
    check(pin24, 24'h000001, "qualified source lost");
  endtask

  // Conversion pulse width, and silence when not routed or not alert
  task automatic t_conv_pulse();
    apply(1'b1, 24'h000002, 24'h000000);
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'h000002);
    // Earlier scenarios left high runs behind, so count from here
    pc = pulse_count + 16'h0001;
    conv_pulse();
    check({8'h00, high_width}, PULSE_EXP, "pulse width");
    check({8'h00, pulse_count}, {8'h00, pc}, "pulse count");
    pc = pulse_count;
    apply(1'b0, 24'h000002, 24'h000000);
    conv_pulse();
    check({8'h00, pulse_count}, {8'h00, pc}, "pulse off alert");
    apply(1'b1, 24'h000002, 24'h000000);
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'h000000);
    conv_pulse();
    check({8'h00, pulse_count}, {8'h00, pc}, "pulse while unrouted");
  endtask

  // A second completion eleven cycles in restarts the full width
  task automatic t_pulse_restart();
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'h000002);
    @(posedge clk);
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (9) @(posedge clk);
    conv_pulse();
    check({8'h00, high_width}, PULSE_EXP + 24'h00000B, "restart width");
  endtask

  // Reset in mid-run drops a written mask and releases the pin
  task automatic t_mid_reset();
    wr_reg(sap_pkg::ROUTE_MASK_OFS, 24'hFFFFFF);
    apply(1'b1, 24'hFFFFFF, 24'hFFFFFF);
    check(pin24, 24'h000001, "pin low before reset");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(sap_pkg::ROUTE_MASK_OFS, d);
    check(d, sap_pkg::ROUTE_MASK_RST, "mask kept over reset");
    check(pin24, 24'h000000, "pin high after reset");
  endtask

  // Whole run needs about eight hundred cycles; the ceiling leaves room
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    sys_rst = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
    pin_alert_func = 1'b0;
    alert_enable = 24'h000000;
    alert_source = 24'h000000;
    conv_done = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_and_regs();
    t_route_each_bit();
    t_gating();
    t_conv_pulse();
    t_pulse_restart();
    t_mid_reset();
    give_verdict();
  end
endmodule
